/* File: speed_cmd_pkg.sv */
// Constants, register map and carrier types for the speed command unit.
package speed_cmd_pkg;

   // Clock rate and the millisecond tick derived from it.
   localparam int unsigned CLK_HZ    = 200_000_000;
   localparam int unsigned MS_PER_S  = 1000;
   localparam logic [31:0] MS_CYCLES = 32'(CLK_HZ / MS_PER_S);

   // Parameter addresses on the communication port.
   localparam logic [15:0] ADDR_MODE      = 16'h0102;
   localparam logic [15:0] ADDR_PRESET1   = 16'h0112;
   localparam logic [15:0] ADDR_PRESET2   = 16'h0114;
   localparam logic [15:0] ADDR_PRESET3   = 16'h0116;
   localparam logic [15:0] ADDR_ACCEL     = 16'h0144;
   localparam logic [15:0] ADDR_DECEL     = 16'h0146;
   localparam logic [15:0] ADDR_ROUND     = 16'h0148;
   localparam logic [15:0] ADDR_MAXSPD    = 16'h0150;
   localparam logic [15:0] ADDR_SPEED_MON = 16'h0160;

   // Reset values.
   localparam logic [1:0]  MODE_RST   = 2'h0;
   localparam logic [31:0] PRESET_RST = 32'h00000000;
   localparam logic [15:0] ACCEL_RST  = 16'h00C8;
   localparam logic [15:0] DECEL_RST  = 16'h00C8;
   localparam logic [15:0] ROUND_RST  = 16'h0000;
   localparam logic [15:0] MAXSPD_RST = 16'h0BB8;

   // Accepted write ranges.
   localparam logic [31:0] PRESET_MIN = 32'hFFFF3CB0;
   localparam logic [31:0] PRESET_MAX = 32'h0000C350;
   localparam logic [15:0] TIME_MIN   = 16'h0001;
   localparam logic [15:0] RAMP_MAX   = 16'h4E20;
   localparam logic [15:0] ROUND_MAX  = 16'h2710;
   localparam logic [15:0] MAXSPD_MAX = 16'h2710;

   // Mode register field positions.
   localparam int unsigned MODE_ZERO_BIT   = 0;
   localparam int unsigned MODE_TORQUE_BIT = 1;

   // Speed is kept in 0.1 r/min; 3000 r/min is the span of one ramp time constant.
   localparam logic [31:0] RAMP_SPAN      = 32'h00007530;
   localparam logic [16:0] UNITS_PER_RPM  = 17'h0000A;
   localparam int unsigned ANALOG_FS_BITS = 15;

   typedef enum logic [1:0] {
      SRC_ANALOG,
      SRC_ZERO,
      SRC_PRESET
   } src_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } param_req_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] rdata;
   } param_rsp_t;

   typedef struct packed {
      logic signed [31:0] speed;
      logic               limit_mode;
      logic               bypass;
   } speed_out_t;

endpackage

/* File: ramp_dda.sv */
// Rate accumulator that issues one step pulse each time inc has summed to period or more.
module ramp_dda import speed_cmd_pkg::*; (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Rate setting
   input  wire logic        run,
   input  wire logic [31:0] inc,
   input  wire logic [31:0] period,
   // Step out
   output logic             step
);

   typedef struct packed {
      logic [32:0] acc;
      logic        step;
   } dda_state_t;

   dda_state_t cur;
   dda_state_t next_cur;
   logic [32:0] sum;

   // The caller keeps inc below period, so at most one step falls in a cycle.
   always_comb begin
      next_cur = cur;
      next_cur.step = 1'b0;
      sum = cur.acc + {1'b0, inc};
      if (!run) begin
         next_cur.acc = 33'h000000000;
      end else if (sum >= {1'b0, period}) begin
         next_cur.step = 1'b1;
         next_cur.acc = sum - {1'b0, period};
      end else begin
         next_cur.acc = sum;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign step = cur.step;

endmodule

/* File: speed_cmd_select.sv */
// Speed command source selection and S-curve smoothing for the speed loop.
module speed_cmd_select import speed_cmd_pkg::*; (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // Digital select inputs
   input  wire logic               speed_select_bit0,
   input  wire logic               speed_select_bit1,
   // Analog reference, signed code where 32767 stands for +10 V
   input  wire logic signed [15:0] analog_code,
   // Parameter access
   input  wire param_req_t         param_req,
   output param_rsp_t              param_rsp,
   // Smoothed command
   output speed_out_t              speed_out
);

   typedef struct packed {
      logic [1:0]         mode;
      logic [2:0][31:0]   preset;
      logic [15:0]        accel;
      logic [15:0]        decel;
      logic [15:0]        round;
      logic [15:0]        maxspd;
      logic signed [31:0] ramp;
      logic signed [31:0] smooth;
      param_rsp_t         rsp;
      speed_out_t         out;
   } cmd_state_t;

   cmd_state_t cur;
   cmd_state_t next_cur;

   logic [1:0]         sel;
   src_t               src;
   logic [16:0]        max_units;
   logic signed [33:0] analog_prod;
   logic signed [31:0] analog_speed;
   logic signed [31:0] target;
   logic               bypass;
   logic               accelerating;
   logic [31:0]        ramp_period;
   logic               ramp_run;
   logic               ramp_step;
   logic signed [31:0] round_err;
   logic [31:0]        round_inc;
   logic [31:0]        round_period;
   logic               round_run;
   logic               round_step;
   logic signed [31:0] wdata_s;

   assign sel = {speed_select_bit1, speed_select_bit0};
   assign wdata_s = $signed(param_req.wdata);

   // Source decode is combinational on the live select pins, so a change takes effect next clock.
   always_comb begin
      if (sel != 2'b00) begin
         src = SRC_PRESET;
      end else if (cur.mode[MODE_ZERO_BIT]) begin
         src = SRC_ZERO;
      end else begin
         src = SRC_ANALOG;
      end
   end

   // Full-scale code maps to the maximum analog speed.
   assign max_units = 17'(cur.maxspd * UNITS_PER_RPM);
   assign analog_prod = analog_code * $signed({1'b0, max_units});
   assign analog_speed = 32'(analog_prod >>> ANALOG_FS_BITS);

   always_comb begin
      case (src)
         SRC_PRESET: target = $signed(cur.preset[sel - 2'b01]);
         SRC_ZERO:   target = 32'sh00000000;
         default:    target = analog_speed;
      endcase
   end

   assign bypass = (src == SRC_ANALOG) && (cur.round == 16'h0000);

   // Moving away from zero uses the acceleration time, toward zero the deceleration time.
   assign accelerating = ((target > cur.ramp) && (cur.ramp >= 0)) ||
                         ((target < cur.ramp) && (cur.ramp <= 0));

   // One unit step every period/RAMP_SPAN cycles gives RAMP_SPAN units per time constant.
   assign ramp_period = accelerating ? 32'(cur.accel * MS_CYCLES)
                                     : 32'(cur.decel * MS_CYCLES);
   assign ramp_run = !bypass && (target != cur.ramp);

   ramp_dda u_ramp (
      .clk    (clk),
      .rst    (rst),
      .run    (ramp_run),
      .inc    (RAMP_SPAN),
      .period (ramp_period),
      .step   (ramp_step)
   );

   // The second stage is a first-order lag on the linear ramp: its slope is the
   // remaining error over the rounding time, which rounds both corners of the ramp.
   assign round_err = cur.ramp - cur.smooth;
   assign round_inc = round_err[31] ? 32'(-round_err) : 32'(round_err);
   assign round_period = 32'(cur.round * MS_CYCLES);
   assign round_run = !bypass && (cur.round != 16'h0000) && (round_err != 0);

   ramp_dda u_round (
      .clk    (clk),
      .rst    (rst),
      .run    (round_run),
      .inc    (round_inc),
      .period (round_period),
      .step   (round_step)
   );

   always_comb begin
      next_cur = cur;

      // Linear ramp stage.
      if (bypass) begin
         next_cur.ramp = target;
      end else if (ramp_step && (target > cur.ramp)) begin
         next_cur.ramp = cur.ramp + 32'sh00000001;
      end else if (ramp_step && (target < cur.ramp)) begin
         next_cur.ramp = cur.ramp - 32'sh00000001;
      end

      // Rounding stage.
      if (bypass) begin
         next_cur.smooth = target;
      end else if (cur.round == 16'h0000) begin
         next_cur.smooth = cur.ramp;
      end else if (round_step && (round_err > 0)) begin
         next_cur.smooth = cur.smooth + 32'sh00000001;
      end else if (round_step && (round_err < 0)) begin
         next_cur.smooth = cur.smooth - 32'sh00000001;
      end

      next_cur.out.speed = next_cur.smooth;
      next_cur.out.limit_mode = cur.mode[MODE_TORQUE_BIT];
      next_cur.out.bypass = bypass;

      // Parameter writes; out-of-range values are ignored and the old value stays, except mode, which takes wdata[1:0] of any write.
      if (param_req.wr) begin
         if (param_req.addr == ADDR_MODE) begin
            next_cur.mode = param_req.wdata[1:0];
         end else if (param_req.addr == ADDR_PRESET1) begin
            if (wdata_s >= $signed(PRESET_MIN) && wdata_s <= $signed(PRESET_MAX)) begin
               next_cur.preset[0] = param_req.wdata;
            end
         end else if (param_req.addr == ADDR_PRESET2) begin
            if (wdata_s >= $signed(PRESET_MIN) && wdata_s <= $signed(PRESET_MAX)) begin
               next_cur.preset[1] = param_req.wdata;
            end
         end else if (param_req.addr == ADDR_PRESET3) begin
            if (wdata_s >= $signed(PRESET_MIN) && wdata_s <= $signed(PRESET_MAX)) begin
               next_cur.preset[2] = param_req.wdata;
            end
         end else if (param_req.addr == ADDR_ACCEL) begin
            if (param_req.wdata[31:16] == 16'h0000 && param_req.wdata[15:0] >= TIME_MIN &&
                param_req.wdata[15:0] <= RAMP_MAX) begin
               next_cur.accel = param_req.wdata[15:0];
            end
         end else if (param_req.addr == ADDR_DECEL) begin
            if (param_req.wdata[31:16] == 16'h0000 && param_req.wdata[15:0] >= TIME_MIN &&
                param_req.wdata[15:0] <= RAMP_MAX) begin
               next_cur.decel = param_req.wdata[15:0];
            end
         end else if (param_req.addr == ADDR_ROUND) begin
            if (param_req.wdata[31:16] == 16'h0000 && param_req.wdata[15:0] <= ROUND_MAX) begin
               next_cur.round = param_req.wdata[15:0];
            end
         end else if (param_req.addr == ADDR_MAXSPD) begin
            if (param_req.wdata[31:16] == 16'h0000 && param_req.wdata[15:0] <= MAXSPD_MAX) begin
               next_cur.maxspd = param_req.wdata[15:0];
            end
         end
      end

      // Reads answer one cycle later; unmapped addresses read as zero.
      next_cur.rsp.valid = param_req.rd;
      next_cur.rsp.rdata = 32'h00000000;
      if (param_req.rd) begin
         if (param_req.addr == ADDR_MODE) begin
            next_cur.rsp.rdata = {30'h00000000, cur.mode};
         end else if (param_req.addr == ADDR_PRESET1) begin
            next_cur.rsp.rdata = cur.preset[0];
         end else if (param_req.addr == ADDR_PRESET2) begin
            next_cur.rsp.rdata = cur.preset[1];
         end else if (param_req.addr == ADDR_PRESET3) begin
            next_cur.rsp.rdata = cur.preset[2];
         end else if (param_req.addr == ADDR_ACCEL) begin
            next_cur.rsp.rdata = {16'h0000, cur.accel};
         end else if (param_req.addr == ADDR_DECEL) begin
            next_cur.rsp.rdata = {16'h0000, cur.decel};
         end else if (param_req.addr == ADDR_ROUND) begin
            next_cur.rsp.rdata = {16'h0000, cur.round};
         end else if (param_req.addr == ADDR_MAXSPD) begin
            next_cur.rsp.rdata = {16'h0000, cur.maxspd};
         end else if (param_req.addr == ADDR_SPEED_MON) begin
            next_cur.rsp.rdata = cur.out.speed;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur <= '0;
         cur.mode <= MODE_RST;
         cur.preset <= {3{PRESET_RST}};
         cur.accel <= ACCEL_RST;
         cur.decel <= DECEL_RST;
         cur.round <= ROUND_RST;
         cur.maxspd <= MAXSPD_RST;
      end else begin
         cur <= next_cur;
      end
   end

   assign param_rsp = cur.rsp;
   assign speed_out = cur.out;

endmodule

/* File: speed_cmd_chk.sv */
// Port-level assertions for the speed command unit.
module speed_cmd_chk import speed_cmd_pkg::*; (
   // Clock and reset
   input wire logic               clk,
   input wire logic               rst,
   // Inputs
   input wire logic               speed_select_bit0,
   input wire logic               speed_select_bit1,
   input wire logic signed [15:0] analog_code,
   input wire param_req_t         param_req,
   // Outputs
   input wire param_rsp_t         param_rsp,
   input wire speed_out_t         speed_out
);
   wire logic rd_acc = param_req.rd && param_req.addr == ADDR_ACCEL;
   wire logic rd_dec = param_req.rd && param_req.addr == ADDR_DECEL;
   wire logic rd_rnd = param_req.rd && param_req.addr == ADDR_ROUND;
   wire logic wr_mode = param_req.wr && param_req.addr == ADDR_MODE;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   rd_answer_a: assert property (param_req.rd |=> param_rsp.valid)
      else $error("read not answered");
   rsp_cause_a: assert property (param_rsp.valid |-> $past(param_req.rd))
      else $error("answer without read");
   rdata_idle_a: assert property (!param_rsp.valid |-> param_rsp.rdata == 32'h0)
      else $error("read data not zero when idle");
   accel_range_a: assert property (rd_acc |=> param_rsp.rdata inside {[TIME_MIN:RAMP_MAX]})
      else $error("accel time out of range");
   decel_range_a: assert property (rd_dec |=> param_rsp.rdata inside {[TIME_MIN:RAMP_MAX]})
      else $error("decel time out of range");
   round_range_a: assert property (rd_rnd |=> param_rsp.rdata <= 32'(ROUND_MAX))
      else $error("rounding time out of range");
   ramp_step_a: assert property (!speed_out.bypass [*3] |-> speed_out.speed - $past(speed_out.speed) inside {-1, 0, 1})
      else $error("smoothed speed jumped");
   no_bypass_a: assert property ((speed_select_bit0 || speed_select_bit1) [*2] |-> !speed_out.bypass)
      else $error("bypass with preset source");
   limit_mode_a: assert property (wr_mode ##1 !param_req.wr [*2] |-> speed_out.limit_mode == $past(param_req.wdata[MODE_TORQUE_BIT], 2))
      else $error("limit mode does not follow mode");
endmodule

bind speed_cmd_select speed_cmd_chk chk (
   .clk(clk), .rst(rst), .speed_select_bit0(speed_select_bit0), .speed_select_bit1(speed_select_bit1),
   .analog_code(analog_code), .param_req(param_req), .param_rsp(param_rsp), .speed_out(speed_out));

/* File: select_driver.sv */
// Motion controller model that drives the two speed select inputs.
module select_driver (
   // Clock
   input  wire logic       clk,
   // Requested select code
   input  wire logic [1:0] code,
   // Select inputs of the drive
   output logic            speed_select_bit0,
   output logic            speed_select_bit1
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {speed_select_bit1, speed_select_bit0} = 2'h0;
   // The controller output stage changes just after its clock edge.
   always @(posedge clk) begin
      #1 {speed_select_bit1, speed_select_bit0} = code;
   end
endmodule

/* File: speed_cmd_select_tb.sv */
// Self-checking bench for the speed command unit.
module speed_cmd_select_tb import speed_cmd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic [1:0]         code = 2'h0;
   logic               b0;
   logic               b1;
   logic signed [15:0] analog_code = 16'sh0000;
   param_req_t         req = '0;
   param_rsp_t         rsp;
   speed_out_t         so;
   logic [31:0]        seed = 32'hEEE8D120;
   logic [31:0]        rd_data;
   int                 errors = 0;
   int                 total_checks = 0;
   int                 pre;
   int                 cur = 0;
   logic [15:0] ta [6] = '{ADDR_ACCEL, ADDR_ACCEL, ADDR_DECEL, ADDR_ROUND, ADDR_PRESET1, ADDR_PRESET1};
   logic [31:0] tw [6] = '{32'h0, 32'h4E21, 32'h4E20, 32'h2711, 32'hC351, PRESET_MIN};
   logic [31:0] te [6] = '{ACCEL_RST, ACCEL_RST, 32'h4E20, ROUND_RST, PRESET_RST, PRESET_MIN};
   logic [15:0] pa [4] = '{ADDR_PRESET1, ADDR_PRESET2, ADDR_PRESET3, ADDR_PRESET3};
   logic [1:0]  sc [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
   always #2.5 clk = ~clk;
   select_driver drv (.clk(clk), .code(code), .speed_select_bit0(b0), .speed_select_bit1(b1));
   speed_cmd_select uut (.clk(clk), .rst(rst), .speed_select_bit0(b0), .speed_select_bit1(b1),
      .analog_code(analog_code), .param_req(req), .param_rsp(rsp), .speed_out(so));
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Ramp length: the part toward zero runs at the decel rate, the part away at the accel rate.
   function automatic int ramp_cycles(int from, int to, int ta_ms, int td_ms);
      int f;
      int t;
      int tw_u;
      int aw_u;
      f = from < 0 ? -from : from;
      t = to < 0 ? -to : to;
      tw_u = (from * to < 0) ? f : (f > t ? f - t : 0);
      aw_u = (from * to < 0) ? t : (t > f ? t - f : 0);
      return (tw_u * td_ms + aw_u * ta_ms) * 20 / 3;
   endfunction
   function automatic logic [31:0] exp_analog(int c);
      return 32'((c * int'(MAXSPD_RST) * 10) >>> 15);
   endfunction
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic chk_time(string what, int exp, int got);
      total_checks++;
      if (got < exp - 10 || got > exp + 10) begin
         errors++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(logic [15:0] a, logic [31:0] d);
      @(posedge clk) #1;
      req = '{1'b1, 1'b0, a, d};
      @(posedge clk) #1;
      req = '0;
   endtask
   task automatic rd(logic [15:0] a);
      @(posedge clk) #1;
      req = '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk) #1;
      req = '0;
      chk("read valid", 32'h1, {31'h0, rsp.valid});
      rd_data = rsp.rdata;
   endtask
   task automatic ramp_to(int tgt, int exp_c);
      int n;
      n = 0;
      while (so.speed !== 32'(tgt) && n < 20000) begin
         @(posedge clk) #1;
         n++;
      end
      if (n >= 20000) begin
         errors++;
         report_and_stop();
      end
      chk("speed", 32'(tgt), so.speed);
      chk_time("ramp cycles", exp_c, n);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      rd(ADDR_DECEL);
      chk("decel reset", DECEL_RST, rd_data);
      rd(16'h0200);
      chk("unmapped read", 32'h00000000, rd_data);
      for (int i = 0; i < 6; i++) begin
         wr(ta[i], tw[i]);
         rd(ta[i]);
         chk("param", te[i], rd_data);
      end
      wr(ADDR_ACCEL, 32'h2);
      wr(ADDR_DECEL, 32'h1);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         pre = (i == 0) ? 200 : (i == 1) ? -200 : int'(seed % 32'h191) - 200;
         wr(pa[i], 32'(pre));
         code = sc[i];
         ramp_to(pre, ramp_cycles(cur, pre, 2, 1));
         cur = pre;
         rd(ADDR_SPEED_MON);
         chk("speed monitor", 32'(pre), rd_data);
      end
      wr(ADDR_MODE, 32'h3);
      repeat (2) @(posedge clk);
      chk("limit mode", 32'h1, {31'h0, so.limit_mode});
      analog_code = 16'sh3039;
      code = 2'h0;
      ramp_to(0, ramp_cycles(cur, 0, 2, 1));
      wr(ADDR_ROUND, 32'h1);
      wr(ADDR_MODE, 32'h0);
      repeat (3) @(posedge clk);
      chk("limit mode", 32'h0, {31'h0, so.limit_mode});
      chk("bypass", 32'h0, {31'h0, so.bypass});
      wr(ADDR_ROUND, 32'h0);
      for (int i = 0; i < 5; i++) begin
         seed = lfsr(seed);
         analog_code = (i == 0) ? 16'sh3039 : (i == 1) ? 16'sh7FFF : (i == 2) ? 16'sh8000 : 16'(seed);
         repeat (3) @(posedge clk);
         #1;
         chk("bypass", 32'h1, {31'h0, so.bypass});
         chk("analog speed", exp_analog(int'(analog_code)), so.speed);
      end
      report_and_stop();
   end
endmodule
